/* File: rtl/wdt_defs.svh */
// register offsets, field positions, reset values and divider figures
// assumes a 32-bit axi4-lite register port, word aligned
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define WDT_CTRL_OFFSET      8'h00
`define WDT_CFG_OFFSET       8'h04
`define WDT_STATUS_OFFSET    8'h08
`define WDT_MASK_OFFSET      8'h0c
`define WDT_COUNT_OFFSET     8'h10

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WDT_CTRL_SW_EN_BIT   0
`define WDT_CFG_PS_LSB       0
`define WDT_CFG_PS_MSB       3
`define WDT_CFG_PRESEL_BIT   4
`define WDT_CFG_WINDOW_DISABLE_CFG_BIT   6
`define WDT_CFG_HWEN_BIT     7
`define WDT_ST_TIMEOUT_BIT   0
`define WDT_ST_WAKE_BIT      1
`define WDT_ST_EARLY_BIT     2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WDT_CFG_RESET        8'h5f
`define WDT_CFG_WMASK        8'hdf
`define WDT_STATUS_RESET     3'h0
`define WDT_MASK_RESET       3'h0

// ----------------------------------------------------------------
// timing: oscillator figure and prescaler divisors
// ----------------------------------------------------------------
`define WDT_OSC_KHZ          31
`define WDT_BASE_SHORT_MS    1
`define WDT_BASE_LONG_MS     4
`define WDT_PRE_SHORT_BITS   5
`define WDT_PRE_LONG_BITS    7

`endif

/* File: rtl/wdt_pkg.sv */
// types shared by the watchdog design files
// assumes wdt_defs.svh supplies the numeric constants
package wdt_pkg;

   // ----------------------------------------------------------------
   // power mode of the core as the watchdog sees it
   // ----------------------------------------------------------------
   typedef enum logic {
      MODE_RUN,
      MODE_POWER_SAVE
   } power_mode_t;

   // ----------------------------------------------------------------
   // axi response codes
   // ----------------------------------------------------------------
   typedef logic [1:0] axi_resp_t;
   localparam axi_resp_t RESP_OKAY   = 2'h0;
   localparam axi_resp_t RESP_SLVERR = 2'h2;

endpackage : wdt_pkg

/* File: rtl/wdt_tick_counter.sv */
// one stage of the watchdog count chain: counts enabled ticks
// assumes clear has priority over counting, synchronous reset
`timescale 1ns/100ps
`default_nettype none

module wdt_tick_counter #(
   parameter int WIDTH = 7
) (
   // clock and reset
   input  wire  logic             aclk,
   input  wire  logic             aresetn,
   // control
   input  wire  logic             clear,
   input  wire  logic             inc,
   // state
   output logic [WIDTH-1:0]       count
);

   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;

   assign count_d = clear ? '0 : (inc ? count_q + 1'b1 : count_q);
   assign count   = count_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         count_q <= '0;
      else
         count_q <= count_d;
   end

endmodule : wdt_tick_counter

`default_nettype wire

/* File: rtl/windowed_watchdog_timer.sv */
// windowed watchdog timer with an axi4-lite register port
// assumes low_power_rc_osc_tick is a one-cycle pulse per oscillator
// period, synchronous to aclk, and core events are one-cycle pulses
//
// Notes on behaviour
// - count ticks of the low-power oscillator; enable it
// - prescaler divides by 32 or 128
// - base period about 1 ms or 4 ms
// - postscaler ratio 1:1 to 1:32768, 16 steps
// - any device reset clears the count chain
// - completed clock switch clears the count chain
// - power-save entry clears the count chain
// - leaving power save clears the count chain
// - clear instruction restarts the whole chain
// - time-out in power save wakes the core
// - sticky time-out flag, cleared only by software
// - windowed: early clear resets like a time-out
// - windowed mode when window-disable bit is zero
// - hardware enable forces the watchdog always on
// - otherwise software enable bit runs the watchdog
// - every device reset clears software enable
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "wdt_defs.svh"

module windowed_watchdog_timer #(
   parameter int PRE_W  = 7,
   parameter int POST_W = 15
) (
   // clock and reset
   input  wire  logic               aclk,
   input  wire  logic               aresetn,
   // axi4-lite write address
   input  wire  logic               s_axi_awvalid,
   output logic                     s_axi_awready,
   input  wire  logic [7:0]         s_axi_awaddr,
   input  wire  logic [2:0]         s_axi_awprot,
   // axi4-lite write data
   input  wire  logic               s_axi_wvalid,
   output logic                     s_axi_wready,
   input  wire  logic [31:0]        s_axi_wdata,
   input  wire  logic [3:0]         s_axi_wstrb,
   // axi4-lite write response
   output logic                     s_axi_bvalid,
   input  wire  logic               s_axi_bready,
   output wdt_pkg::axi_resp_t       s_axi_bresp,
   // axi4-lite read address
   input  wire  logic               s_axi_arvalid,
   output logic                     s_axi_arready,
   input  wire  logic [7:0]         s_axi_araddr,
   input  wire  logic [2:0]         s_axi_arprot,
   // axi4-lite read data
   output logic                     s_axi_rvalid,
   input  wire  logic               s_axi_rready,
   output logic [31:0]              s_axi_rdata,
   output wdt_pkg::axi_resp_t       s_axi_rresp,
   // oscillator
   input  wire  logic               low_power_rc_osc_tick,
   output logic                     low_power_rc_osc_en,
   // core events
   input  wire  logic               clear_watchdog_instr,
   input  wire  logic               power_save_instr,
   input  wire  logic               power_save_exit,
   input  wire  logic               clock_switch_done,
   input  wire  logic               device_reset_event,
   // results
   output logic                     wdt_reset_req,
   output logic                     wake_req,
   output logic                     timeout_flag,
   output logic                     irq
);

   import wdt_pkg::*;

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   logic              sw_en_q;
   logic [7:0]        cfg_q;
   logic [2:0]        status_q;
   logic [2:0]        status_d;
   logic [2:0]        mask_q;
   power_mode_t       mode_q;
   power_mode_t       mode_d;
   logic              reset_req_q;
   logic              wake_req_q;

   // ----------------------------------------------------------------
   // axi4-lite slave: one write and one read at a time
   // ----------------------------------------------------------------
   logic              aw_held_q;
   logic [7:0]        aw_addr_q;
   logic              w_held_q;
   logic [31:0]       w_data_q;
   logic [3:0]        w_strb_q;
   logic              bvalid_q;
   axi_resp_t         bresp_q;
   logic              rvalid_q;
   logic [31:0]       rdata_q;
   axi_resp_t         rresp_q;

   wire aw_take  = s_axi_awvalid & s_axi_awready;
   wire w_take   = s_axi_wvalid & s_axi_wready;
   wire ar_take  = s_axi_arvalid & s_axi_arready;
   wire wr_fire  = aw_held_q & w_held_q & ~bvalid_q;

   assign s_axi_awready = ~aw_held_q & ~bvalid_q;
   assign s_axi_wready  = ~w_held_q & ~bvalid_q;
   assign s_axi_arready = ~rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rdata   = rdata_q;
   assign s_axi_rresp   = rresp_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_q <= 1'b0;
         aw_addr_q <= 8'h00;
      end
      else if (aw_take)
      begin
         aw_held_q <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end
      else if (wr_fire)
         aw_held_q <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_q <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end
      else if (w_take)
      begin
         w_held_q <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end
      else if (wr_fire)
         w_held_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------
   wire wr_ctrl   = wr_fire & (aw_addr_q == `WDT_CTRL_OFFSET);
   wire wr_cfg    = wr_fire & (aw_addr_q == `WDT_CFG_OFFSET);
   wire wr_status = wr_fire & (aw_addr_q == `WDT_STATUS_OFFSET);
   wire wr_mask   = wr_fire & (aw_addr_q == `WDT_MASK_OFFSET);
   wire wr_count  = wr_fire & (aw_addr_q == `WDT_COUNT_OFFSET);
   wire wr_hit    = wr_ctrl | wr_cfg | wr_status | wr_mask | wr_count;
   wire lane0     = w_strb_q[0];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // configuration fields
   // ----------------------------------------------------------------
   wire [3:0] post_sel = cfg_q[`WDT_CFG_PS_MSB:`WDT_CFG_PS_LSB];
   wire       pre_long = cfg_q[`WDT_CFG_PRESEL_BIT];
   wire       win_dis  = cfg_q[`WDT_CFG_WINDOW_DISABLE_CFG_BIT];
   wire       hw_en    = cfg_q[`WDT_CFG_HWEN_BIT];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cfg_q <= `WDT_CFG_RESET;
      else if (wr_cfg & lane0)
         cfg_q <= w_data_q[7:0] & `WDT_CFG_WMASK;
   end

   // ----------------------------------------------------------------
   // enable and oscillator request
   // ----------------------------------------------------------------
   wire running = hw_en | sw_en_q;
   assign low_power_rc_osc_en = running;

   // our own reset request is a device reset too
   wire any_dev_reset = device_reset_event | reset_req_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         sw_en_q <= 1'b0;
      else if (any_dev_reset)
         sw_en_q <= 1'b0;
      else if (wr_ctrl & lane0)
         sw_en_q <= w_data_q[`WDT_CTRL_SW_EN_BIT];
   end

   // ----------------------------------------------------------------
   // count chain
   // ----------------------------------------------------------------
   logic [PRE_W-1:0]  pre_cnt;
   logic [POST_W-1:0] post_cnt;

   wire in_save  = (mode_q == MODE_POWER_SAVE);
   wire tick     = low_power_rc_osc_tick & running;

   // divide by 32 gives about 1 ms, by 128 about 4 ms at 31 kHz
   wire [PRE_W-1:0] pre_last = pre_long ?
      PRE_W'((1 << `WDT_PRE_LONG_BITS) - 1) :
      PRE_W'((1 << `WDT_PRE_SHORT_BITS) - 1);
   wire [POST_W-1:0] post_last =
      POST_W'((32'h1 << post_sel) - 32'h1);

   wire pre_wrap = tick & (pre_cnt == pre_last);
   wire timeout  = pre_wrap & (post_cnt == post_last);

   // position within the period, with period scaled the same way
   wire [21:0] position = pre_long ?
      22'({post_cnt, pre_cnt[`WDT_PRE_LONG_BITS-1:0]}) :
      22'({post_cnt, pre_cnt[`WDT_PRE_SHORT_BITS-1:0]});
   // shift amount kept 5 bits wide so ratios above 1:256 do not wrap
   wire [4:0]  period_exp = {1'b0, post_sel} +
      (pre_long ? 5'(`WDT_PRE_LONG_BITS) : 5'(`WDT_PRE_SHORT_BITS));
   wire [22:0] period = 23'(32'h1 << period_exp);
   wire [22:0] win_start = period - (period >> 2);
   wire        in_window = ({1'b0, position} >= win_start);

   // a clear only means something during normal execution
   wire clr_valid   = clear_watchdog_instr & running & ~in_save;
   wire early_clear = clr_valid & ~win_dis & ~in_window;
   wire good_clear  = clr_valid & ~early_clear;

   wire chain_clear = ~running
                    | any_dev_reset
                    | clock_switch_done
                    | power_save_instr
                    | power_save_exit
                    | good_clear
                    | early_clear;

   wdt_tick_counter #(
      .WIDTH (PRE_W)
   ) u_prescaler (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (chain_clear | pre_wrap),
      .inc     (tick),
      .count   (pre_cnt)
   );

   wdt_tick_counter #(
      .WIDTH (POST_W)
   ) u_postscaler (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (chain_clear | timeout),
      .inc     (pre_wrap),
      .count   (post_cnt)
   );

   // ----------------------------------------------------------------
   // time-out results
   // ----------------------------------------------------------------
   // a clear in the same cycle wins over the time-out, which then raises no reset request
   wire to_wake  = timeout & in_save & ~power_save_instr;
   wire to_reset = (timeout & ~in_save & ~chain_clear) | early_clear;
   wire any_to   = to_wake | to_reset;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         reset_req_q <= 1'b0;
         wake_req_q  <= 1'b0;
      end
      else
      begin
         reset_req_q <= to_reset;
         wake_req_q  <= to_wake;
      end
   end

   assign wdt_reset_req = reset_req_q;
   assign wake_req      = wake_req_q;

   // ----------------------------------------------------------------
   // power mode tracking
   // ----------------------------------------------------------------
   // sleep and idle status bits live in the core; a wake or reset request clears them
   always_comb
   begin
      mode_d = mode_q;
      unique case (mode_q)
         MODE_RUN:
            if (power_save_instr)
               mode_d = MODE_POWER_SAVE;
         MODE_POWER_SAVE:
            if (power_save_exit | to_wake | any_dev_reset)
               mode_d = MODE_RUN;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mode_q <= MODE_RUN;
      else
         mode_q <= mode_d;
   end

   // ----------------------------------------------------------------
   // sticky status, write one to clear, set wins
   // ----------------------------------------------------------------
   wire [2:0] st_set = {early_clear, to_wake, any_to};
   wire [2:0] st_clr = (wr_status & lane0) ? w_data_q[2:0] : 3'h0;

   // the flag survives our own reset request on purpose
   assign status_d = (status_q & ~st_clr) | st_set;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status_q <= `WDT_STATUS_RESET;
      else
         status_q <= status_d;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         mask_q <= `WDT_MASK_RESET;
      else if (wr_mask & lane0)
         mask_q <= w_data_q[2:0];
   end

   assign timeout_flag = status_q[`WDT_ST_TIMEOUT_BIT];
   assign irq          = |(status_q & mask_q);

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   wire rd_ctrl   = (s_axi_araddr == `WDT_CTRL_OFFSET);
   wire rd_cfg    = (s_axi_araddr == `WDT_CFG_OFFSET);
   wire rd_status = (s_axi_araddr == `WDT_STATUS_OFFSET);
   wire rd_mask   = (s_axi_araddr == `WDT_MASK_OFFSET);
   wire rd_count  = (s_axi_araddr == `WDT_COUNT_OFFSET);
   wire rd_hit    = rd_ctrl | rd_cfg | rd_status | rd_mask | rd_count;

   wire [31:0] rd_word =
        ({32{rd_ctrl}}   & {30'h0, running, sw_en_q})
      | ({32{rd_cfg}}    & {24'h0, cfg_q})
      | ({32{rd_status}} & {29'h0, status_q})
      | ({32{rd_mask}}   & {29'h0, mask_q})
      | ({32{rd_count}}  & {10'h0, position});

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_word;
         rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rready)
         rvalid_q <= 1'b0;
   end

   // protection bits carry nothing this block acts on
   wire unused_ok = ^{s_axi_awprot, s_axi_arprot, w_data_q[31:8], w_strb_q[3:1]};

endmodule : windowed_watchdog_timer

`default_nettype wire

/* File: verification/wdt_props.sv */
// concurrent checks on the watchdog top-level ports
// assumes one clock domain; bound to the top module at the foot
`timescale 1ns/100ps
`default_nettype none

module wdt_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // register bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // core events and results
   input wire logic clear_watchdog_instr,
   input wire logic clock_switch_done,
   input wire logic device_reset_event,
   input wire logic low_power_rc_osc_en,
   input wire logic wdt_reset_req,
   input wire logic wake_req,
   input wire logic timeout_flag
);
   default clocking dcb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // --------------------
   // sequences
   // --------------------
   sequence s_both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_resp_due;
      ##[1:2] s_axi_bvalid;
   endsequence
   sequence s_any_req;
      wdt_reset_req || wake_req;
   endsequence

   // --------------------
   // assertions
   // --------------------
   a_write_answer: assert property (s_both_taken |-> s_resp_due)
      else $error("write response missing");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data missing");
   a_reset_pulse: assert property (
      wdt_reset_req && !clear_watchdog_instr |=> !wdt_reset_req)
      else $error("reset request wider than one cycle");
   a_wake_pulse: assert property (wake_req |=> !wake_req)
      else $error("wake request wider than one cycle");
   a_req_sets_flag: assert property (s_any_req |-> timeout_flag)
      else $error("time-out without flag");
   a_flag_sticky: assert property (
      $fell(timeout_flag) |-> ##[0:1] s_axi_bvalid)
      else $error("flag dropped without a write");
   a_req_needs_osc: assert property (
      s_any_req |-> $past(low_power_rc_osc_en))
      else $error("time-out while stopped");
   a_req_exclusive: assert property (!(wdt_reset_req && wake_req))
      else $error("wake and reset together");
   a_event_quiets: assert property (
      (clock_switch_done || device_reset_event) && !clear_watchdog_instr
      |=> !wdt_reset_req)
      else $error("time-out beside a chain clear");
endmodule : wdt_props

bind windowed_watchdog_timer wdt_props wdt_props_inst (
   .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
   .clear_watchdog_instr, .clock_switch_done, .device_reset_event,
   .low_power_rc_osc_en, .wdt_reset_req, .wake_req, .timeout_flag
);

`default_nettype wire

/* File: verification/core_model.sv */
// core partner: issues watchdog events as one-cycle pulses
// assumes issue() is called by the bench between clock edges
`timescale 1ns/100ps
`default_nettype none

module core_model (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // watchdog results
   input  wire logic wake_req,
   input  wire logic wdt_reset_req,
   // instructions and events
   output var  logic clear_watchdog_instr,
   output var  logic power_save_instr,
   output var  logic power_save_exit,
   output var  logic clock_switch_done,
   output var  logic device_reset_event
);
   logic asleep_q = 1'b0;

   // own sleep/idle status; the watchdog's wake or reset request clears it
   always @(posedge aclk)
   begin
      if (!aresetn || wdt_reset_req || wake_req)
         asleep_q <= 1'b0; // cleared on a wake or reset request
      else if (power_save_instr)
         asleep_q <= 1'b1;
   end

   initial
   begin
      {clear_watchdog_instr, power_save_instr, power_save_exit} = 3'h0;
      {clock_switch_done, device_reset_event} = 2'h0;
   end

   // 0 clear, 1 power save, 2 leave power save, 3 clock switch, 4 reset
   task automatic issue(input int k);
      @(posedge aclk);
      clear_watchdog_instr <= (k == 0) && !asleep_q; // only in normal run
      power_save_instr     <= (k == 1);
      power_save_exit      <= (k == 2) && asleep_q;
      clock_switch_done    <= (k == 3);
      device_reset_event   <= (k == 4);
      @(posedge aclk);
      {clear_watchdog_instr, power_save_instr, power_save_exit} <= 3'h0;
      {clock_switch_done, device_reset_event} <= 2'h0;
   endtask : issue
endmodule : core_model

`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench: register bus master, oscillator ticks, core model
// assumes a tick every cycle, or every other one while tick_half is set
`timescale 1ns/100ps
`default_nettype none
`include "wdt_defs.svh"

module testbench;
   import wdt_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, low_power_rc_osc_tick = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   axi_resp_t   s_axi_bresp, s_axi_rresp;
   logic        clear_watchdog_instr, power_save_instr, power_save_exit, clock_switch_done;
   logic        device_reset_event, low_power_rc_osc_en, wdt_reset_req, wake_req;
   logic        timeout_flag, irq;
   int          error_cnt = 0;
   int          n_compared = 0;
   logic        tick_half = 1'b0;

   always #2.5 aclk = ~aclk;

   always @(posedge aclk)
      low_power_rc_osc_tick <= aresetn && (!tick_half || !low_power_rc_osc_tick);

   windowed_watchdog_timer windowed_watchdog_timer_inst (
      .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
      .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
      .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
      .low_power_rc_osc_tick, .low_power_rc_osc_en, .clear_watchdog_instr,
      .power_save_instr, .power_save_exit, .clock_switch_done, .device_reset_event,
      .wdt_reset_req, .wake_req, .timeout_flag, .irq);
   core_model core_model_inst (
      .aclk, .aresetn, .wake_req, .wdt_reset_req, .clear_watchdog_instr,
      .power_save_instr, .power_save_exit, .clock_switch_done, .device_reset_event);

   // --------------------
   // shared tasks
   // --------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude;
      $display("compared %0d, mismatched %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   task automatic stall;
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, 32'h0, 32'h1);
      conclude();
   endtask : stall

   // master holds each channel until its own handshake edge
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awprot  <= a[4:2];
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (n = 0; n < 50 && s_axi_bvalid !== 1'b1; n++)
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
      if (n == 50)
         stall();
      check(32'(s_axi_bresp), (a <= `WDT_COUNT_OFFSET && a[1:0] == 2'h0) ?
            32'(RESP_OKAY) : 32'(RESP_SLVERR));
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input axi_resp_t er);
      int n;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arprot  <= a[4:2];
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (n = 0; n < 50 && s_axi_rvalid !== 1'b1; n++)
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1)
            s_axi_arvalid <= 1'b0;
      end
      if (n == 50)
         stall();
      check(s_axi_rdata, exp);
      check(32'(s_axi_rresp), 32'(er));
      s_axi_rready <= 1'b0;
   endtask : rd

   // cycles from the current edge until a reset or wake request shows
   task automatic measure(output int n);
      n = 0;
      #1;
      while (wdt_reset_req !== 1'b1 && wake_req !== 1'b1)
      begin
         @(posedge aclk);
         #1;
         n++;
         if (n > 5000)
            stall();
      end
   endtask : measure

   // --------------------
   // scenarios
   // --------------------
   task automatic t_reset;
      wr(8'h1c, 32'hff);
      s_axi_wstrb <= 4'he;
      wr(`WDT_CTRL_OFFSET, 32'h1);
      s_axi_wstrb <= 4'hf;
      rd(`WDT_CFG_OFFSET, 32'h5f, RESP_OKAY);
      rd(`WDT_CTRL_OFFSET, 32'h0, RESP_OKAY);
      rd(8'h1c, 32'h0, RESP_SLVERR);
      check(32'(low_power_rc_osc_en), 32'h0);
      $display("reset values done");
   endtask : t_reset

   task automatic t_period;
      logic [7:0] cfg [3] = '{8'h40, 8'h50, 8'h42};
      int         len [3] = '{32, 128, 128};
      int         n;
      for (int i = 0; i < 3; i++)
      begin
         wr(`WDT_CFG_OFFSET, {24'h0, cfg[i]});
         wr(`WDT_CTRL_OFFSET, 32'h1);
         check(32'(low_power_rc_osc_en), 32'h1);
         core_model_inst.issue(0);
         measure(n);
         check(32'(n), 32'(len[i]));
         check(32'(wdt_reset_req), 32'h1);
      end
      rd(`WDT_CTRL_OFFSET, 32'h0, RESP_OKAY);
      rd(`WDT_STATUS_OFFSET, 32'h1, RESP_OKAY);
      wr(`WDT_MASK_OFFSET, 32'h1);
      check(32'(irq), 32'h1);
      wr(`WDT_STATUS_OFFSET, 32'h1);
      check(32'({timeout_flag, irq}), 32'h0);
      wr(`WDT_CTRL_OFFSET, 32'h1);
      core_model_inst.issue(4);
      rd(`WDT_CTRL_OFFSET, 32'h0, RESP_OKAY);
      $display("periods and flag done");
   endtask : t_period

   // each event restarts the chain 20 cycles after a clear; leaving power save comes 20 cycles after entering it
   task automatic t_clears;
      int ev [5] = '{0, 3, 2, 4, 1};
      int n;
      wr(`WDT_CFG_OFFSET, 32'hc0);
      wr(`WDT_CTRL_OFFSET, 32'h0);
      check(32'(low_power_rc_osc_en), 32'h1);
      foreach (ev[i])
      begin
         core_model_inst.issue(0);
         repeat (20) @(posedge aclk);
         if (ev[i] == 2)
         begin
            core_model_inst.issue(1);
            repeat (20) @(posedge aclk);
         end
         core_model_inst.issue(ev[i]);
         measure(n);
         check(32'(n), 32'd32);
         check(32'(wake_req), 32'(ev[i] == 1));
      end
      $display("chain clears done");
   endtask : t_clears

   // period 128, window opens at 96
   task automatic t_window;
      int n;
      wr(`WDT_CFG_OFFSET, 32'h82);
      core_model_inst.issue(4);
      wr(`WDT_STATUS_OFFSET, 32'h7);
      core_model_inst.issue(0);
      measure(n);
      check(32'(n < 2), 32'h1);
      rd(`WDT_STATUS_OFFSET, 32'h5, RESP_OKAY);
      rd(`WDT_COUNT_OFFSET, 32'h3, RESP_OKAY);
      repeat (93) @(posedge aclk);
      core_model_inst.issue(0);
      measure(n);
      check(32'(n), 32'd128);
      $display("window done");
   endtask : t_window

   // half-rate ticks double the cycles, whatever the tick phase
   task automatic t_slow;
      int n;
      wr(`WDT_CFG_OFFSET, 32'hc0);
      tick_half <= 1'b1;
      core_model_inst.issue(0);
      measure(n);
      check(32'((n + 1) / 2), 32'd32);
      $display("slow ticks done");
   endtask : t_slow

   initial
   begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_period();
      t_clears();
      t_window();
      t_slow();
      conclude();
   end
endmodule : testbench

`default_nettype wire
